// ---- src/cab_consts.svh ----
// constants of the arithmetic and bit datapath: opcodes, map, timing
`ifndef CAB_CONSTS_SVH
`define CAB_CONSTS_SVH

// timing: one instruction cycle in clock periods
`define CAB_CLK_NS      50
`define CAB_ICYC_NS     200
`define CAB_ICYC_CLKS   ((`CAB_ICYC_NS + `CAB_CLK_NS - 1) / `CAB_CLK_NS)

// data memory reached by 7-bit file addresses
`define CAB_MEM_WORDS   128

// opcode prefixes of the 14-bit instruction word
`define CAB_OPC_ADD_LITERAL_WORKING   6'h3E
`define CAB_OPC_AND_LITERAL_WORKING   6'h39
`define CAB_OPC_ADD_WORKING_FILE   6'h07
`define CAB_OPC_AND_WORKING_FILE   6'h05
`define CAB_OPC_ARITH_SHIFT_RIGHT_FILE    6'h37
`define CAB_OPC_ADD_WORKING_FILE_CARRY  6'h3D
`define CAB_OPC_BCF     4'h4
`define CAB_OPC_ADD_LITERAL_TO_POINTER  7'h62

// special file addresses
`define CAB_FA_INDF0    7'h00
`define CAB_FA_INDF1    7'h01
`define CAB_FA_PCL      7'h02

// wishbone register byte offsets
`define CAB_REG_INSTR   8'h00
`define CAB_REG_STATUS  8'h04
`define CAB_REG_W       8'h08
`define CAB_REG_PTR0    8'h0C
`define CAB_REG_PTR1    8'h10
`define CAB_REG_PC      8'h14
`define CAB_REG_MADR    8'h18
`define CAB_REG_MDATA   8'h1C

// status register field positions
`define CAB_STB_C       0
`define CAB_STB_DC      1
`define CAB_STB_Z       2
`define CAB_STB_BUSY    8
`define CAB_STB_CYC     12

// reset values
`define CAB_RST_W       8'h00
`define CAB_RST_PTR     16'h0000
`define CAB_RST_PC      8'h00

`endif

// ---- src/cab_pkg.sv ----
// types of the arithmetic and bit datapath
`include "cab_consts.svh"
package cab_pkg;
  typedef enum logic [3:0] {
    CAB_OP_NOP, CAB_OP_ADD_LITERAL_TO_POINTER, CAB_OP_AND_LITERAL_WORKING, CAB_OP_ADD_LITERAL_WORKING, CAB_OP_ADD_WORKING_FILE,
    CAB_OP_AND_WORKING_FILE, CAB_OP_ARITH_SHIFT_RIGHT_FILE, CAB_OP_ADD_WORKING_FILE_CARRY, CAB_OP_BCF
  } cab_op_t;

  typedef enum logic [1:0] {CAB_IDLE, CAB_EXEC, CAB_WAIT} cab_fsm_t;

  typedef struct packed {
    cab_fsm_t                          fsm;
    logic [13:0]                       op;
    logic [7:0]                        w;
    logic                              c;
    logic                              dc;
    logic                              z;
    logic [15:0]                       ptr0;
    logic [15:0]                       ptr1;
    logic [7:0]                        pc;
    logic [6:0]                        madr;
    logic [4:0]                        wait_cnt;
    logic [1:0]                        last_cyc;
    logic                              busy;
    logic                              ack;
    logic [31:0]                       rdat;
    logic [`CAB_MEM_WORDS-1:0][7:0]    mem;
  } cab_state_t;
endpackage

// ---- src/cab_alu_if.sv ----
// operand and result bundle between the datapath and its alu
`timescale 1ns/1ns
interface cab_alu_if;
  import cab_pkg::*;
  cab_op_t    op;
  logic [7:0] w;
  logic [7:0] f;
  logic [7:0] k;
  logic       cin;
  logic       dest;
  logic [2:0] bsel;
  logic [7:0] res;
  logic       c;
  logic       dc;
  logic       z;
  logic       upd_c;
  logic       upd_dc;
  logic       upd_z;
  logic       to_file;
  modport dp  (output op, w, f, k, cin, dest, bsel,
               input  res, c, dc, z, upd_c, upd_dc, upd_z, to_file);
  modport alu (input  op, w, f, k, cin, dest, bsel,
               output res, c, dc, z, upd_c, upd_dc, upd_z, to_file);
endinterface

// ---- src/cab_alu.sv ----
// combinational alu: add, and, shift, bit clear with flag results
`timescale 1ns/1ns
module cab_alu
  import cab_pkg::*;
(
  // operands in, results out
  cab_alu_if.alu a
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] rhs;
  logic       cin;

  // shared adder; digit carry from a separate low-nibble sum
  always_comb begin
    rhs = (a.op == CAB_OP_ADD_LITERAL_WORKING || a.op == CAB_OP_AND_LITERAL_WORKING) ? a.k : a.f;
    cin = (a.op == CAB_OP_ADD_WORKING_FILE_CARRY) ? a.cin : 1'b0;
    sum = {1'b0, a.w} + {1'b0, rhs} + {8'h00, cin};
    nib = {1'b0, a.w[3:0]} + {1'b0, rhs[3:0]} + {4'h0, cin};
    a.res     = a.w;
    a.c       = a.cin;
    a.dc      = 1'b0;
    a.upd_c   = 1'b0;
    a.upd_dc  = 1'b0;
    a.upd_z   = 1'b0;
    a.to_file = 1'b0;
    unique case (a.op)
      CAB_OP_ADD_LITERAL_WORKING, CAB_OP_ADD_WORKING_FILE, CAB_OP_ADD_WORKING_FILE_CARRY: begin
        a.res     = sum[7:0];
        a.c       = sum[8];
        a.dc      = nib[4];
        a.upd_c   = 1'b1;
        a.upd_dc  = 1'b1;
        a.upd_z   = 1'b1;
        a.to_file = (a.op != CAB_OP_ADD_LITERAL_WORKING) && a.dest;
      end
      CAB_OP_AND_LITERAL_WORKING, CAB_OP_AND_WORKING_FILE: begin
        a.res     = a.w & rhs;
        a.upd_z   = 1'b1;
        a.to_file = (a.op == CAB_OP_AND_WORKING_FILE) && a.dest;
      end
      CAB_OP_ARITH_SHIFT_RIGHT_FILE: begin
        a.res     = {a.f[7], a.f[7:1]};
        a.c       = a.f[0];
        a.upd_c   = 1'b1;
        a.upd_z   = 1'b1;
        a.to_file = a.dest;
      end
      CAB_OP_BCF: begin
        a.res     = a.f & ~(8'h01 << a.bsel);
        a.to_file = 1'b1;
      end
      CAB_OP_NOP, CAB_OP_ADD_LITERAL_TO_POINTER: begin
        a.res     = a.w;
      end
    endcase
    a.z = (a.res == 8'h00);
  end
endmodule

// ---- src/cab_exec_unit.sv ----
// execution unit for pointer add, add/and, shift and bit clear
// Functional notes
// - pc-changing instruction takes two cycles, second one idles
// - indirect access through pointer with msb set adds one cycle
// - pointer add sums signed 6-bit literal into pointer 0 or 1
// - pointer sum wraps modulo 16 bits
// - and with literal writes working register, updates zero only
// - add literal writes working register, updates carry, digit, zero
// - add file routes by destination bit, updates carry, digit, zero
// - and file routes by destination bit, updates zero only
// - arithmetic shift right keeps msb, bit 0 to carry
// - add with carry includes carry flag, routes by destination bit
// - bit clear zeroes one chosen bit, no flag change
// - pointer add decoded by fixed prefix, pointer bit, 6-bit literal
`timescale 1ns/1ns
module cab_exec_unit
  import cab_pkg::*;
#(
  parameter int ICYC_CLKS = `CAB_ICYC_CLKS
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // execution status
  output logic             busy_o
);
  // counter of wait clocks is 5 bits: 3 cycles times up to 8 clocks
  if (ICYC_CLKS < 1 || ICYC_CLKS > 8) begin : g_bad_icyc
    $error("ICYC_CLKS must lie in 1..8");
  end

  localparam cab_state_t RST_STATE = '{
    fsm: CAB_IDLE, op: 14'h0000, w: `CAB_RST_W, c: 1'b0, dc: 1'b0,
    z: 1'b0, ptr0: `CAB_RST_PTR, ptr1: `CAB_RST_PTR, pc: `CAB_RST_PC,
    madr: 7'h00, wait_cnt: 5'h00, last_cyc: 2'h0, busy: 1'b0,
    ack: 1'b0, rdat: 32'h0000_0000, mem: '0};

  cab_state_t s;
  cab_state_t next_s;
  cab_alu_if  alu_bus ();

  cab_alu u_alu (
    .a (alu_bus.alu)
  );

  // opcode classification by fixed prefixes
  function automatic cab_op_t decode_op(input logic [13:0] op);
    cab_op_t k;
    k = CAB_OP_NOP;
    if (op[13:7] == `CAB_OPC_ADD_LITERAL_TO_POINTER)      k = CAB_OP_ADD_LITERAL_TO_POINTER;
    else if (op[13:8] == `CAB_OPC_AND_LITERAL_WORKING)  k = CAB_OP_AND_LITERAL_WORKING;
    else if (op[13:8] == `CAB_OPC_ADD_LITERAL_WORKING)  k = CAB_OP_ADD_LITERAL_WORKING;
    else if (op[13:8] == `CAB_OPC_ADD_WORKING_FILE)  k = CAB_OP_ADD_WORKING_FILE;
    else if (op[13:8] == `CAB_OPC_AND_WORKING_FILE)  k = CAB_OP_AND_WORKING_FILE;
    else if (op[13:8] == `CAB_OPC_ARITH_SHIFT_RIGHT_FILE)   k = CAB_OP_ARITH_SHIFT_RIGHT_FILE;
    else if (op[13:8] == `CAB_OPC_ADD_WORKING_FILE_CARRY) k = CAB_OP_ADD_WORKING_FILE_CARRY;
    else if (op[13:10] == `CAB_OPC_BCF)   k = CAB_OP_BCF;
    return k;
  endfunction

  cab_op_t     opk;
  logic [6:0]  fadr;
  logic        ind0;
  logic        ind1;
  logic [6:0]  paddr;
  logic [7:0]  fval;
  logic        file_op;
  logic        extra;
  logic        pc_mod;
  logic [1:0]  ncyc;
  logic [4:0]  tot_clks;
  logic [15:0] ksext;
  logic        acc;
  logic        wr;
  logic        idle;
  logic        launch;
  logic [31:0] rd;

  // operand fetch: indirect file addresses go through a pointer
  always_comb begin
    opk     = decode_op(s.op);
    fadr    = s.op[6:0];
    file_op = opk inside {CAB_OP_ADD_WORKING_FILE, CAB_OP_AND_WORKING_FILE, CAB_OP_ARITH_SHIFT_RIGHT_FILE,
                          CAB_OP_ADD_WORKING_FILE_CARRY, CAB_OP_BCF};
    ind0    = file_op && (fadr == `CAB_FA_INDF0);
    ind1    = file_op && (fadr == `CAB_FA_INDF1);
    paddr   = ind0 ? s.ptr0[6:0] : (ind1 ? s.ptr1[6:0] : fadr);
    fval    = (paddr == `CAB_FA_PCL) ? s.pc : s.mem[paddr];
    // pointer msb set means a slow program-space access
    extra   = (ind0 && s.ptr0[15]) || (ind1 && s.ptr1[15]);
    ksext   = {{10{s.op[5]}}, s.op[5:0]};
  end

  // alu operands straight from the held instruction
  always_comb begin
    alu_bus.op   = (s.fsm == CAB_EXEC) ? opk : CAB_OP_NOP;
    alu_bus.w    = s.w;
    alu_bus.f    = fval;
    alu_bus.k    = s.op[7:0];
    alu_bus.cin  = s.c;
    alu_bus.dest = s.op[7];
    alu_bus.bsel = s.op[9:7];
  end

  // writing the program counter low byte turns the instruction into two
  always_comb begin
    pc_mod   = alu_bus.to_file && (paddr == `CAB_FA_PCL);
    ncyc     = 2'd1 + {1'b0, pc_mod} + {1'b0, extra};
    tot_clks = 5'(int'(ncyc) * ICYC_CLKS);
  end

  // wishbone decode; register writes are refused while busy
  always_comb begin
    acc    = wb_cyc_i && wb_stb_i && !s.ack;
    wr     = acc && wb_we_i && wb_sel_i[0];
    idle   = (s.fsm == CAB_IDLE);
    launch = wr && idle && (wb_adr_i == `CAB_REG_INSTR);
    rd     = 32'h0000_0000;
    unique case (wb_adr_i)
      `CAB_REG_INSTR:  rd = {18'h0_0000, s.op};
      `CAB_REG_STATUS: begin
        rd[`CAB_STB_C]                  = s.c;
        rd[`CAB_STB_DC]                 = s.dc;
        rd[`CAB_STB_Z]                  = s.z;
        rd[`CAB_STB_BUSY]               = s.busy;
        rd[`CAB_STB_CYC+1:`CAB_STB_CYC] = s.last_cyc;
      end
      `CAB_REG_W:      rd = {24'h00_0000, s.w};
      `CAB_REG_PTR0:   rd = {16'h0000, s.ptr0};
      `CAB_REG_PTR1:   rd = {16'h0000, s.ptr1};
      `CAB_REG_PC:     rd = {24'h00_0000, s.pc};
      `CAB_REG_MADR:   rd = {25'h000_0000, s.madr};
      `CAB_REG_MDATA:  rd = {24'h00_0000, s.mem[s.madr]};
      default:         rd = 32'h0000_0000;
    endcase
  end

  // next state: bus slave, then sequencer and write-back
  always_comb begin
    next_s      = s;
    next_s.ack  = acc;
    if (acc) begin
      next_s.rdat = rd;
    end
    if (wr && idle) begin
      unique case (wb_adr_i)
        `CAB_REG_STATUS: begin
          next_s.c  = wb_dat_i[`CAB_STB_C];
          next_s.dc = wb_dat_i[`CAB_STB_DC];
          next_s.z  = wb_dat_i[`CAB_STB_Z];
        end
        `CAB_REG_W:     next_s.w = wb_dat_i[7:0];
        `CAB_REG_PTR0:  next_s.ptr0[7:0] = wb_dat_i[7:0];
        `CAB_REG_PTR1:  next_s.ptr1[7:0] = wb_dat_i[7:0];
        `CAB_REG_PC:    next_s.pc = wb_dat_i[7:0];
        `CAB_REG_MADR:  next_s.madr = wb_dat_i[6:0];
        `CAB_REG_MDATA: next_s.mem[s.madr] = wb_dat_i[7:0];
        default: ;
      endcase
    end
    // upper pointer bytes follow their own byte lane
    if (acc && wb_we_i && wb_sel_i[1] && idle) begin
      if (wb_adr_i == `CAB_REG_PTR0) next_s.ptr0[15:8] = wb_dat_i[15:8];
      if (wb_adr_i == `CAB_REG_PTR1) next_s.ptr1[15:8] = wb_dat_i[15:8];
    end
    unique case (s.fsm)
      CAB_IDLE: begin
        if (launch) begin
          next_s.op   = wb_dat_i[13:0];
          next_s.fsm  = CAB_EXEC;
          next_s.busy = 1'b1;
        end
      end
      CAB_EXEC: begin
        // commit in the first clock, then idle out the remaining cycles
        if (opk == CAB_OP_ADD_LITERAL_TO_POINTER) begin
          if (s.op[6]) next_s.ptr1 = s.ptr1 + ksext;
          else         next_s.ptr0 = s.ptr0 + ksext;
        end
        if (alu_bus.to_file) begin
          if (paddr != `CAB_FA_PCL) next_s.mem[paddr] = alu_bus.res;
        end else if (opk != CAB_OP_ADD_LITERAL_TO_POINTER && opk != CAB_OP_NOP) begin
          next_s.w = alu_bus.res;
        end
        if (alu_bus.upd_c)  next_s.c  = alu_bus.c;
        if (alu_bus.upd_dc) next_s.dc = alu_bus.dc;
        if (alu_bus.upd_z)  next_s.z  = alu_bus.z;
        next_s.pc       = pc_mod ? alu_bus.res : s.pc + 8'h01;
        next_s.last_cyc = ncyc;
        next_s.wait_cnt = tot_clks - 5'd1;
        if (tot_clks == 5'd1) begin
          next_s.fsm  = CAB_IDLE;
          next_s.busy = 1'b0;
        end else begin
          next_s.fsm  = CAB_WAIT;
        end
      end
      CAB_WAIT: begin
        next_s.wait_cnt = s.wait_cnt - 5'd1;
        if (s.wait_cnt == 5'd1) begin
          next_s.fsm  = CAB_IDLE;
          next_s.busy = 1'b0;
        end
      end
    endcase
  end

  // single state register, frozen while the enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= RST_STATE;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign busy_o   = s.busy;

  // helper: enabled clocks spent busy, for the cycle-count checks
  logic [5:0] busy_run;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_run <= 6'h00;
    end else if (ce_i) begin
      busy_run <= s.busy ? busy_run + 6'h01 : 6'h00;
    end
  end

  sequence seq_launch;
    ce_i && launch;
  endsequence

  sequence seq_exec;
    s.fsm == CAB_EXEC;
  endsequence

  property p_launch_exec;
    @(posedge clk_i) disable iff (rst_i)
      seq_launch |=> seq_exec;
  endproperty

  chk_launch_exec: assert property (p_launch_exec)
    else $error("launch did not enter execute");

  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s.ack) |=> !s.ack)
    else $error("ack held longer than one cycle");

  chk_busy_len: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s.busy && !next_s.busy) |->
      (int'(busy_run) + 1 == int'(s.last_cyc) * ICYC_CLKS))
    else $error("busy length differs from cycle count");

  chk_extra_cyc: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s.fsm == CAB_EXEC && extra) |=> s.last_cyc >= 2'd2)
    else $error("slow indirect access lost its extra cycle");

  chk_ptr_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s.fsm == CAB_EXEC && opk == CAB_OP_ADD_LITERAL_TO_POINTER && !s.op[6]) |=>
      s.ptr0 == $past(s.ptr0) + $past(ksext))
    else $error("pointer 0 sum wrong");

  chk_flags_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s.fsm == CAB_EXEC &&
     (opk == CAB_OP_ADD_LITERAL_TO_POINTER || opk == CAB_OP_BCF)) |=>
      $stable({s.c, s.dc, s.z}))
    else $error("flags changed by flag-free instruction");

  chk_and_literal_working_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s.fsm == CAB_EXEC && opk == CAB_OP_AND_LITERAL_WORKING) |=>
      (s.z == (s.w == 8'h00)) && $stable({s.c, s.dc}))
    else $error("literal and flag result wrong");

  chk_add_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s.fsm == CAB_EXEC && opk == CAB_OP_ADD_LITERAL_WORKING) |=>
      {s.c, s.w} == {1'b0, $past(s.w)} + {1'b0, $past(alu_bus.k)})
    else $error("literal add sum or carry wrong");

  chk_asr_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.fsm == CAB_EXEC && opk == CAB_OP_ARITH_SHIFT_RIGHT_FILE) |->
      alu_bus.res == {fval[7], fval[7:1]} && alu_bus.c == fval[0])
    else $error("arithmetic shift result wrong");

  chk_bcf_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.fsm == CAB_EXEC && opk == CAB_OP_BCF) |->
      !alu_bus.res[s.op[9:7]] &&
      ((alu_bus.res | (8'h01 << s.op[9:7])) ==
       (fval | (8'h01 << s.op[9:7]))))
    else $error("bit clear touched the wrong bits");

  chk_dest_w: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s.fsm == CAB_EXEC && !s.op[7] &&
     (opk == CAB_OP_ADD_WORKING_FILE || opk == CAB_OP_AND_WORKING_FILE ||
      opk == CAB_OP_ADD_WORKING_FILE_CARRY)) |=> s.w == $past(alu_bus.res))
    else $error("destination zero did not reach working register");
endmodule

// ---- tb/cab_exec_unit_test.sv ----
// self-checking bench for the arithmetic and bit execution unit
`timescale 1ns/1ns
`include "cab_consts.svh"
module cab_exec_unit_test
  import cab_pkg::*;
;
  localparam int ICYC = 4;

  typedef struct {
    logic [13:0] op;
    logic [7:0]  w;
    logic [7:0]  f;
    logic [2:0]  st;
    logic [7:0]  ew;
    logic [7:0]  ef;
    logic [2:0]  est;
  } cab_row_t;

  logic        clk_i;
  logic        rst_i;
  logic        ce_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        busy_o;
  int          n_fail;
  int          checked;
  logic [31:0] rd;
  cab_row_t    rows [13];

  cab_exec_unit #(.ICYC_CLKS(ICYC)) cab_exec_unit_inst (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .busy_o   (busy_o)
  );

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // classic single cycle; ack and data taken at the rising edge itself,
  // where the pre-edge values are still visible, then released there
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      $display("[ERR] %0t no bus answer", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] q;
    wb(1'b1, adr, dat, q);
  endtask

  // launch one instruction and measure how long busy stands
  task automatic run(input logic [13:0] op, input int ncyc);
    int cnt;
    wr(`CAB_REG_INSTR, {18'h0_0000, op});
    cnt = 1;
    do begin
      @(negedge clk_i);
      if (busy_o === 1'b1) cnt++;
    end while (busy_o !== 1'b0 && cnt < 200);
    chk(cnt, ncyc * ICYC);
  endtask

  // stalls are cut short well beyond the longest expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    n_fail = 0;
    checked = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    // carry cases, flag preservation and both destinations for add file, shift and add with carry
    rows[0]  = '{{`CAB_OPC_ADD_LITERAL_WORKING, 8'h01}, 8'hff, 8'h00, 3'h0, 8'h00, 8'h00, 3'h7};
    rows[1]  = '{{`CAB_OPC_ADD_LITERAL_WORKING, 8'h08}, 8'h08, 8'h00, 3'h0, 8'h10, 8'h00, 3'h2};
    rows[2]  = '{{`CAB_OPC_AND_LITERAL_WORKING, 8'h0f}, 8'hf0, 8'h00, 3'h3, 8'h00, 8'h00, 3'h7};
    rows[3]  = '{{`CAB_OPC_AND_LITERAL_WORKING, 8'ha5}, 8'hff, 8'h00, 3'h5, 8'ha5, 8'h00, 3'h1};
    rows[4]  = '{{`CAB_OPC_ADD_WORKING_FILE, 8'h20}, 8'h80, 8'h80, 3'h0, 8'h00, 8'h80, 3'h5};
    rows[5]  = '{{`CAB_OPC_ADD_WORKING_FILE, 8'ha0}, 8'h0f, 8'h01, 3'h0, 8'h0f, 8'h10, 3'h2};
    rows[6]  = '{{`CAB_OPC_AND_WORKING_FILE, 8'ha0}, 8'h3c, 8'hf0, 3'h3, 8'h3c, 8'h30, 3'h3};
    rows[7]  = '{{`CAB_OPC_ARITH_SHIFT_RIGHT_FILE, 8'h20}, 8'h00, 8'h81, 3'h2, 8'hc0, 8'h81, 3'h3};
    rows[8]  = '{{`CAB_OPC_ARITH_SHIFT_RIGHT_FILE, 8'ha0}, 8'h55, 8'h01, 3'h0, 8'h55, 8'h00, 3'h5};
    rows[9]  = '{{`CAB_OPC_ADD_WORKING_FILE_CARRY, 8'h20}, 8'h7f, 8'h00, 3'h1, 8'h80, 8'h00, 3'h2};
    rows[10] = '{{`CAB_OPC_ADD_WORKING_FILE_CARRY, 8'ha0}, 8'hff, 8'h00, 3'h1, 8'hff, 8'h00, 3'h7};
    rows[11] = '{{`CAB_OPC_BCF, 3'h7, 7'h20}, 8'h00, 8'hff, 3'h5, 8'h00, 8'h7f, 3'h5};
    rows[12] = '{{`CAB_OPC_BCF, 3'h0, 7'h20}, 8'h00, 8'hff, 3'h2, 8'h00, 8'hfe, 3'h2};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset state
    wb(1'b0, `CAB_REG_W, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    wb(1'b0, `CAB_REG_STATUS, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    wb(1'b0, `CAB_REG_PTR0, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
    // table of ordinary operations on file address 0x20
    foreach (rows[i]) begin
      wr(`CAB_REG_W, {24'h00_0000, rows[i].w});
      wr(`CAB_REG_MADR, 32'h0000_0020);
      wr(`CAB_REG_MDATA, {24'h00_0000, rows[i].f});
      wr(`CAB_REG_STATUS, {29'h0, rows[i].st});
      run(rows[i].op, 1);
      wb(1'b0, `CAB_REG_W, 32'h0, rd);
      chk(rd, {24'h00_0000, rows[i].ew});
      wb(1'b0, `CAB_REG_MDATA, 32'h0, rd);
      chk(rd, {24'h00_0000, rows[i].ef});
      wb(1'b0, `CAB_REG_STATUS, 32'h0, rd);
      chk(rd, {29'h0, rows[i].est} | 32'h0000_1000);
      $display("row %0d done", i);
    end
    // pointer add: wrap both ways, literal bounds, flags untouched
    wr(`CAB_REG_STATUS, 32'h0000_0007);
    wr(`CAB_REG_PTR0, 32'h0000_ffff);
    run({`CAB_OPC_ADD_LITERAL_TO_POINTER, 1'b0, 6'h01}, 1);
    wb(1'b0, `CAB_REG_PTR0, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    run({`CAB_OPC_ADD_LITERAL_TO_POINTER, 1'b0, 6'h1f}, 1);
    wb(1'b0, `CAB_REG_PTR0, 32'h0, rd);
    chk(rd, 32'h0000_001f);
    wr(`CAB_REG_PTR1, 32'h0000_0000);
    run({`CAB_OPC_ADD_LITERAL_TO_POINTER, 1'b1, 6'h20}, 1);
    wb(1'b0, `CAB_REG_PTR1, 32'h0, rd);
    chk(rd, 32'h0000_ffe0);
    wb(1'b0, `CAB_REG_PTR0, 32'h0, rd);
    chk(rd, 32'h0000_001f);
    wb(1'b0, `CAB_REG_STATUS, 32'h0, rd);
    chk(rd, 32'h0000_1007);
    $display("pointer test done");
    // indirect operand: pointer msb set costs one more cycle
    wr(`CAB_REG_STATUS, 32'h0000_0000);
    wr(`CAB_REG_PTR0, 32'h0000_8020);
    wr(`CAB_REG_MADR, 32'h0000_0020);
    wr(`CAB_REG_MDATA, 32'h0000_0005);
    wr(`CAB_REG_W, 32'h0000_0003);
    run({`CAB_OPC_ADD_WORKING_FILE, 1'b0, `CAB_FA_INDF0}, 2);
    wb(1'b0, `CAB_REG_W, 32'h0, rd);
    chk(rd, 32'h0000_0008);
    wb(1'b0, `CAB_REG_STATUS, 32'h0, rd);
    chk(rd, 32'h0000_2000);
    wr(`CAB_REG_PTR0, 32'h0000_0020);
    run({`CAB_OPC_ADD_WORKING_FILE, 1'b0, `CAB_FA_INDF0}, 1);
    wb(1'b0, `CAB_REG_W, 32'h0, rd);
    chk(rd, 32'h0000_000d);
    $display("indirect test done");
    // result written to the program counter takes two cycles
    run({`CAB_OPC_ADD_WORKING_FILE, 1'b1, `CAB_FA_PCL}, 2);
    wb(1'b0, `CAB_REG_STATUS, 32'h0, rd);
    chk({30'h0, rd[13:12]}, 32'h0000_0002);
    $display("branch cost test done");
    // unmapped place reads zero and ignores writes
    wr(8'h40, 32'h0000_00aa);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    wb(1'b0, `CAB_REG_W, 32'h0, rd);
    chk(rd, 32'h0000_000d);
    $display("unmapped test done");
    summarize();
  end
endmodule
